//--- rtl/ascc_clkdiv.v
// square-wave divider of the system clock with a programmable half period
`timescale 1ns/100ps
module ascc_clkdiv (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        run,
    input  wire [11:0] half_period,
    output reg         clk_out
);

    reg  [11:0] cnt_r;
    wire [11:0] last_w;

    assign last_w = half_period - 12'h001;

    // stopped divider parks low so the output never glitches on enable
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r   <= 12'h000;
            clk_out <= 1'b0;
        end else if (!run) begin
            cnt_r   <= 12'h000;
            clk_out <= 1'b0;
        end else if (cnt_r >= last_w) begin
            // >= so a shorter period takes effect without a wrap-around
            cnt_r   <= 12'h000;
            clk_out <= ~clk_out;
        end else begin
            cnt_r   <= cnt_r + 12'h001;
        end
    end

endmodule

//--- rtl/ascc_top.v
// supply, charge pump and dual-slope converter control with an ahb-lite slave
`timescale 1ns/100ps
`include "ascc_regs.vh"
module ascc_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    input  wire        comparator_raw,
    output wire        pump_clock,
    output wire        chopper_clock,
    output reg         regulator_enable,
    output reg         regulator_output_hiz,
    output reg         pump_run,
    output reg         pump_bypass,
    output reg         bandgap_enable,
    output reg         bandgap_filter_short,
    output reg         converter_power,
    output reg         integrator_charge,
    output reg         integrator_discharge,
    output reg         gain_input_alt,
    output reg         gain_x4,
    output reg         reference_alt,
    output reg         converter_irq
);

    localparam [1:0] SEL_NONE = 2'd0;
    localparam [1:0] SEL_SUP  = 2'd1;
    localparam [1:0] SEL_CONV = 2'd2;
    localparam [1:0] SEL_CHOP = 2'd3;

    reg  [7:0]  sup_r;
    reg  [7:0]  sup_nxt;
    reg  [7:0]  conv_r;
    reg  [7:0]  conv_nxt;
    reg  [7:0]  chop_r;
    reg  [7:0]  chop_nxt;
    reg         wr_pend_r;
    reg  [1:0]  wr_sel_r;
    reg  [1:0]  addr_sel;
    reg  [7:0]  rd_byte;
    reg         cmp_meta_r;
    reg         cmp_sync_r;
    reg         cmp_prev_r;
    reg         irq_nxt;
    wire        accept_w;
    wire [9:0]  byte_addr_w;
    wire        rise_w;
    wire        fall_w;
    wire [1:0]  phase_w;
    wire [1:0]  trig_w;
    wire [4:0]  pump_div_w;
    wire [2:0]  chop_div_w;
    wire [11:0] pump_half_w;
    wire [11:0] chop_half_w;
    wire        pump_clk_run_w;
    wire        chop_clk_run_w;

    // address phase taken only when the bus is ready and the transfer is real
    assign accept_w    = hsel & hready & htrans[1];
    assign byte_addr_w = haddr[9:0];

    // word decode; indexes times four give the byte addresses
    always @* begin
        if (byte_addr_w == {`ASCC_IDX_SUPPLY, 2'b00})
            addr_sel = SEL_SUP;
        else if (byte_addr_w == {`ASCC_IDX_CONV, 2'b00})
            addr_sel = SEL_CONV;
        else if (byte_addr_w == {`ASCC_IDX_CHOP, 2'b00})
            addr_sel = SEL_CHOP;
        else
            addr_sel = SEL_NONE;
    end

    // data-phase write; the comparator bit is masked so writes cannot touch it
    always @* begin
        sup_nxt  = sup_r;
        conv_nxt = conv_r;
        chop_nxt = chop_r;
        if (wr_pend_r) begin
            case (wr_sel_r)
                SEL_SUP: begin
                    sup_nxt = hwdata[7:0];
                end
                SEL_CONV: begin
                    conv_nxt = hwdata[7:0] & `ASCC_CONV_WMASK;
                end
                SEL_CHOP: begin
                    chop_nxt = hwdata[7:0] & `ASCC_CHOP_WMASK;
                end
                default: begin
                end
            endcase
        end
    end

    // read value built from next-state copies so a read right after a write
    // sees the new value without a wait state
    always @* begin
        case (addr_sel)
            SEL_SUP: begin
                rd_byte = sup_nxt;
            end
            SEL_CONV: begin
                rd_byte = conv_nxt;
                rd_byte[`ASCC_CONV_CMP] = cmp_sync_r;
            end
            SEL_CHOP: begin
                rd_byte = chop_nxt;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // bus slave: zero wait states, always okay, unmapped reads give zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            wr_pend_r <= 1'b0;
            wr_sel_r  <= SEL_NONE;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= accept_w & hwrite;
            if (accept_w) begin
                wr_sel_r <= addr_sel;
            end
            if (accept_w && !hwrite) begin
                hrdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // register storage
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sup_r  <= `ASCC_SUP_RESET;
            conv_r <= `ASCC_CONV_RESET;
            chop_r <= `ASCC_CHOP_RESET;
        end else begin
            sup_r  <= sup_nxt;
            conv_r <= conv_nxt;
            chop_r <= chop_nxt;
        end
    end

    assign phase_w    = conv_r[`ASCC_CONV_PH_MSB:`ASCC_CONV_PH_LSB];
    assign trig_w     = conv_r[`ASCC_CONV_TM_MSB:`ASCC_CONV_TM_LSB];
    assign pump_div_w = sup_r[`ASCC_SUP_DIV_MSB:`ASCC_SUP_DIV_LSB];
    assign chop_div_w = chop_r[`ASCC_CHOP_DIV_MSB:`ASCC_CHOP_DIV_LSB];

    // analog controls, each held in a flop; module enable gates the regulator, pump, bandgap enable and converter power
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            regulator_enable     <= 1'b0;
            regulator_output_hiz <= 1'b1;
            pump_run             <= 1'b0;
            pump_bypass          <= 1'b1;
            bandgap_enable       <= 1'b0;
            bandgap_filter_short <= 1'b1;
            converter_power      <= 1'b0;
            integrator_charge    <= 1'b0;
            integrator_discharge <= 1'b0;
            gain_input_alt       <= 1'b0;
            gain_x4              <= 1'b0;
            reference_alt        <= 1'b0;
        end else begin
            regulator_enable     <= sup_r[`ASCC_SUP_MOD_EN];
            regulator_output_hiz <= ~sup_r[`ASCC_SUP_MOD_EN];
            // pump enable counts only with the module on
            pump_run    <= sup_r[`ASCC_SUP_MOD_EN] & sup_r[`ASCC_SUP_PUMP_EN];
            pump_bypass <= ~(sup_r[`ASCC_SUP_MOD_EN] & sup_r[`ASCC_SUP_PUMP_EN]);
            bandgap_enable       <= sup_r[`ASCC_SUP_MOD_EN];
            bandgap_filter_short <= ~sup_r[`ASCC_SUP_BG_QST];
            // converter loses its supply whenever the module is off
            converter_power <= sup_r[`ASCC_SUP_MOD_EN] & conv_r[`ASCC_CONV_PWR];
            integrator_charge    <= (phase_w == `ASCC_PH_CHARGE);
            integrator_discharge <= (phase_w == `ASCC_PH_DISCHARGE);
            gain_input_alt       <= chop_r[`ASCC_CHOP_IN_SEL];
            gain_x4              <= chop_r[`ASCC_CHOP_GAIN];
            reference_alt        <= chop_r[`ASCC_CHOP_REF_SEL];
        end
    end

    // pump clock: half period of 8*(n+1) gives a full period of 16*(n+1)
    assign pump_half_w    = {7'h00, pump_div_w} * `ASCC_PUMP_HALF_BASE
                          + `ASCC_PUMP_HALF_BASE;
    assign pump_clk_run_w = pump_run;

    ascc_clkdiv u_pump_div (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .run         (pump_clk_run_w),
        .half_period (pump_half_w),
        .clk_out     (pump_clock)
    );

    // chopper clock: base of 32 system clocks, doubled per code step
    assign chop_half_w    = `ASCC_CHOP_HALF_BASE << chop_div_w;
    assign chop_clk_run_w = converter_power & conv_r[`ASCC_CONV_CHOP_EN];

    ascc_clkdiv u_chop_div (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .run         (chop_clk_run_w),
        .half_period (chop_half_w),
        .clk_out     (chopper_clock)
    );

    // comparator synchroniser; the second stage and its delayed copy in the third flop feed the edge logic, the first stage never does
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
            cmp_prev_r <= 1'b0;
        end else begin
            cmp_meta_r <= comparator_raw;
            cmp_sync_r <= cmp_meta_r;
            cmp_prev_r <= cmp_sync_r;
        end
    end

    assign rise_w = cmp_sync_r & ~cmp_prev_r;
    // the discharge end shows as this falling edge
    assign fall_w = ~cmp_sync_r & cmp_prev_r;

    // edge select; a dead converter raises nothing from a floating comparator
    always @* begin
        case (trig_w)
            `ASCC_TM_NONE: irq_nxt = 1'b0;
            `ASCC_TM_RISE: irq_nxt = rise_w;
            `ASCC_TM_FALL: irq_nxt = fall_w;
            `ASCC_TM_BOTH: irq_nxt = rise_w | fall_w;
            default:       irq_nxt = 1'b0;
        endcase
    end

    // one-cycle request per qualifying edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            converter_irq <= 1'b0;
        end else begin
            converter_irq <= irq_nxt & converter_power;
        end
    end

endmodule

//--- shared/ascc_regs.vh
// register indexes, field positions, reset values and divider constants
`ifndef ASCC_REGS_VH
`define ASCC_REGS_VH

// register indexes; byte address is four times the index
`define ASCC_IDX_SUPPLY      8'h1f
`define ASCC_IDX_CONV        8'h18
`define ASCC_IDX_CHOP        8'h19

// supply_pump_control fields
`define ASCC_SUP_MOD_EN      0
`define ASCC_SUP_PUMP_EN     1
`define ASCC_SUP_BG_QST      2
`define ASCC_SUP_DIV_LSB     3
`define ASCC_SUP_DIV_MSB     7
`define ASCC_SUP_RESET       8'h00

// converter_control_reg fields
`define ASCC_CONV_PWR        0
`define ASCC_CONV_PH_LSB     1
`define ASCC_CONV_PH_MSB     2
`define ASCC_CONV_CMP        3
`define ASCC_CONV_TM_LSB     4
`define ASCC_CONV_TM_MSB     5
`define ASCC_CONV_CHOP_EN    6
`define ASCC_CONV_WMASK      8'h77
`define ASCC_CONV_RESET      8'h00

// chopper_divider_reg fields
`define ASCC_CHOP_DIV_LSB    0
`define ASCC_CHOP_DIV_MSB    2
`define ASCC_CHOP_IN_SEL     3
`define ASCC_CHOP_REF_SEL    4
`define ASCC_CHOP_GAIN       7
`define ASCC_CHOP_WMASK      8'h9f
`define ASCC_CHOP_RESET      8'h00

// integrator phase and trigger mode codes
`define ASCC_PH_CHARGE       2'b01
`define ASCC_PH_DISCHARGE    2'b10
`define ASCC_TM_NONE         2'b00
`define ASCC_TM_RISE         2'b01
`define ASCC_TM_FALL         2'b10
`define ASCC_TM_BOTH         2'b11

// half periods in system clocks: pump base is 16/2, chopper base is 32/2
`define ASCC_PUMP_HALF_BASE  12'h008
`define ASCC_CHOP_HALF_BASE  12'h010

`endif

//--- verification/ascc_bench.sv
// self-checking bench for the supply, pump and converter control block
`timescale 1ns/100ps
`include "ascc_regs.vh"
module ascc_bench;
    reg         hclk, hresetn, hsel, hwrite, comparator_raw;
    reg  [1:0]  htrans;
    reg  [2:0]  hsize;
    reg  [31:0] haddr, hwdata, rd;
    reg  [7:0]  idx, m [0:255];
    wire        hreadyout, hresp, pump_clock, chopper_clock, regulator_enable, pump_run;
    wire        regulator_output_hiz, pump_bypass, bandgap_enable, bandgap_filter_short;
    wire        converter_power, integrator_charge, integrator_discharge, gain_input_alt;
    wire        gain_x4, reference_alt, converter_irq;
    wire [31:0] hrdata;
    wire [7:0]  sup = m[`ASCC_IDX_SUPPLY];
    wire [7:0]  cnv = m[`ASCC_IDX_CONV];
    wire [7:0]  chp = m[`ASCC_IDX_CHOP];
    integer     n_errors, checks_done, seed, i, k, p;

    ascc_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .comparator_raw, .pump_clock,
        .chopper_clock, .regulator_enable, .regulator_output_hiz, .pump_run, .pump_bypass,
        .bandgap_enable, .bandgap_filter_short, .converter_power, .integrator_charge,
        .integrator_discharge, .gain_input_alt, .gain_x4, .reference_alt, .converter_irq);

    always #25 hclk = ~hclk;

    task chk(input [31:0] seen, input [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task complete_run;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // bounded wait for hready, so a stuck slave ends the run
    task wait_rdy;
        integer n;
        for (n = 0; n == 0 || hreadyout !== 1'b1; n = n + 1) begin
            if (n > 16) begin
                n_errors = n_errors + 1;
                complete_run;
            end
            @(posedge hclk);
        end
    endtask

    // one single word transfer, address phase then data phase
    task bus(input w, input [7:0] x, input [7:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, x, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wait_rdy;
        rd = hrdata;
    endtask

    // model keeps only the writable bits; unmapped words keep nothing
    task wr(input [7:0] x, input [7:0] d);
        bus(1'b1, x, d);
        m[x] = d & (x == `ASCC_IDX_SUPPLY ? 8'hff : x == `ASCC_IDX_CONV ? `ASCC_CONV_WMASK :
                    x == `ASCC_IDX_CHOP ? `ASCC_CHOP_WMASK : 8'h00);
    endtask

    task rdchk(input [7:0] x);
        bus(1'b0, x, 8'h00);
        chk(rd, {24'h0, m[x] | (x == `ASCC_IDX_CONV ? {4'h0, comparator_raw, 3'h0} :
                                8'h00)});
    endtask

    // level outputs three edges after the last write has landed
    task outs;
        reg [11:0] s, e;
        repeat (3) @(posedge hclk);
        s = {regulator_enable, regulator_output_hiz, bandgap_enable, pump_run, pump_bypass,
             bandgap_filter_short, converter_power, integrator_charge, integrator_discharge,
             gain_input_alt, gain_x4, reference_alt};
        e = {sup[0], !sup[0], sup[0], sup[0] & sup[1], !(sup[0] & sup[1]), !sup[2],
             sup[0] & cnv[0], cnv[2:1] == 2'b01, cnv[2:1] == 2'b10, chp[3], chp[7], chp[4]};
        chk(s, e);
    endtask

    // rising edge to rising edge in cycles, -1 when the clock stays still
    task period(input s, output integer q);
        integer t0, n;
        reg v, pv;
        q = -1;
        t0 = -1;
        pv = 1'b1;
        for (n = 0; n < 1200 && q < 0; n = n + 1) begin
            @(posedge hclk);
            v = s ? chopper_clock : pump_clock;
            if (v === 1'b1 && pv !== 1'b1) begin
                if (t0 < 0)
                    t0 = n;
                else
                    q = n - t0;
            end
            pv = v;
        end
    endtask

    task cnt(input v, output integer c);
        comparator_raw <= v;
        c = 0;
        repeat (8) begin
            @(posedge hclk);
            if (converter_irq === 1'b1)
                c = c + 1;
        end
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        comparator_raw = 1'b0;
        n_errors = 0;
        checks_done = 0;
        seed = 42026;
        for (i = 0; i < 256; i = i + 1)
            m[i] = 8'h00;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        outs;
        rdchk(`ASCC_IDX_SUPPLY);
        rdchk(`ASCC_IDX_CONV);
        rdchk(`ASCC_IDX_CHOP);
        // random traffic, a quarter of it to an unmapped word
        for (i = 0; i < 32; i = i + 1) begin
            p = $random(seed);
            k = p[5:4];
            idx = k == 0 ? `ASCC_IDX_SUPPLY : k == 1 ? `ASCC_IDX_CONV :
                  k == 2 ? `ASCC_IDX_CHOP : 8'h05;
            comparator_raw <= p[0];
            wr(idx, p[15:8]);
            rdchk(idx);
            outs;
        end
        // module on with quick start low, held about 2ms (40000 clocks), then filtering
        wr(`ASCC_IDX_SUPPLY, 8'h00);
        wr(`ASCC_IDX_SUPPLY, 8'h01);
        repeat (40000) @(posedge hclk);
        outs;
        wr(`ASCC_IDX_SUPPLY, 8'h05);
        outs;
        // every trigger mode, converter powered and unpowered
        for (k = 0; k < 8; k = k + 1) begin
            comparator_raw <= 1'b0;
            wr(`ASCC_IDX_CONV, {2'b00, k[1:0], 3'b000, !k[2]});
            repeat (4) @(posedge hclk);
            cnt(1'b1, p);
            chk(p, k[0] & !k[2]);
            cnt(1'b0, p);
            chk(p, k[1] & !k[2]);
        end
        // pump clock at boundary and typical divider values
        for (i = 0; i < 4; i = i + 1) begin
            k = i == 0 ? 0 : i == 1 ? 5 : i == 2 ? 11 : 31;
            wr(`ASCC_IDX_SUPPLY, {k[4:0], 3'b011});
            period(1'b0, p);
            chk(p, 16 * (k + 1));
        end
        wr(`ASCC_IDX_SUPPLY, 8'h19);
        period(1'b0, p);
        chk(p, -1);
        wr(`ASCC_IDX_SUPPLY, 8'h1a);
        period(1'b0, p);
        chk(p, -1);
        // chopper clock on several divider codes, then stopped
        wr(`ASCC_IDX_SUPPLY, 8'h01);
        for (k = 0; k < 6; k = k + 2) begin
            wr(`ASCC_IDX_CHOP, {5'h00, k[2:0]});
            wr(`ASCC_IDX_CONV, 8'h41);
            period(1'b1, p);
            chk(p, 32 << k);
        end
        wr(`ASCC_IDX_CONV, 8'h01);
        period(1'b1, p);
        chk(p, -1);
        wr(`ASCC_IDX_SUPPLY, 8'h00);
        outs;
        // reset in mid-run while converter and chopper words still hold values
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 256; i = i + 1)
            m[i] = 8'h00;
        outs;
        rdchk(`ASCC_IDX_CONV);
        rdchk(`ASCC_IDX_CHOP);
        complete_run;
    end
endmodule

//--- verification/ascc_monitor.sv
// concurrent checks on the supply, pump and converter control ports
`timescale 1ns/100ps
module ascc_monitor (
    input wire        hclk,
    input wire        hresetn,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        comparator_raw,
    input wire        pump_clock,
    input wire        chopper_clock,
    input wire        regulator_enable,
    input wire        regulator_output_hiz,
    input wire        pump_run,
    input wire        pump_bypass,
    input wire        bandgap_enable,
    input wire        converter_power,
    input wire        integrator_charge,
    input wire        integrator_discharge,
    input wire        converter_irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // supply side and integrator phase outputs must agree with each other
    a_hiz_inverse: assert property (regulator_output_hiz != regulator_enable)
        else $error("hi-z does not oppose regulator enable");
    a_pump_gated: assert property (pump_run |-> regulator_enable)
        else $error("pump runs with module off");
    a_bypass_pump: assert property (pump_bypass != pump_run)
        else $error("pump bypass not inverse of run");
    a_bandgap_reg: assert property (bandgap_enable == regulator_enable)
        else $error("bandgap not following regulator");
    a_conv_supply: assert property (converter_power |-> regulator_enable)
        else $error("converter powered with module off");
    a_phase_onehot: assert property (!(integrator_charge && integrator_discharge))
        else $error("charge and discharge together");
    // clocks must be still once their enable has been low for a cycle
    a_pump_stop: assert property (!pump_run ##1 !pump_run |-> !pump_clock)
        else $error("pump clock high while stopped");
    a_chop_stop: assert property (
        !converter_power ##1 !converter_power |-> !chopper_clock)
        else $error("chopper clock high while stopped");
    // a pulse ends unless a fresh comparator change is already in the pipe;
    // back-to-back comparator changes legally give back-to-back pulses
    a_irq_pulse: assert property (
        converter_irq && $past(comparator_raw, 2) == $past(comparator_raw, 3)
        |=> !converter_irq)
        else $error("interrupt longer than its comparator change");
    // one pulse, three edges after the comparator was sampled changing
    a_irq_cause: assert property (converter_irq |->
        $past(comparator_raw, 3) != $past(comparator_raw, 4))
        else $error("interrupt without comparator change");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
endmodule

bind ascc_top ascc_monitor u_monitor (.hclk, .hresetn, .hreadyout, .hresp, .hrdata,
    .comparator_raw, .pump_clock, .chopper_clock, .regulator_enable, .regulator_output_hiz,
    .pump_run, .pump_bypass, .bandgap_enable, .converter_power, .integrator_charge,
    .integrator_discharge, .converter_irq);
